// *** dzol_ctrl_model.sv ***
// signal controller model: drives phase status, one phase stepping green, yellow, red
`timescale 1ns/100ps
`default_nettype none
module dzol_ctrl_model (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       step,
	output var  logic [7:0] green,
	output var  logic [7:0] yellow,
	output var  logic [7:0] red
);
	logic [1:0] ph0_q;
	always_ff @(posedge sys_clk) begin
		if (reset)
			ph0_q <= 2'h0;
		else if (step)
			ph0_q <= (ph0_q == 2'h2) ? 2'h0 : ph0_q + 2'h1;
	end
	// exactly one colour per phase; the other phases rest on red
	assign green  = {7'h00, ph0_q == 2'h0};
	assign yellow = {7'h00, ph0_q == 2'h1};
	assign red    = {7'h7F, ph0_q == 2'h2};
endmodule // dzol_ctrl_model
`default_nettype wire

// *** dzol_pkg.sv ***
// shared constants and types for the detection zone output logic
package dzol_pkg;
	localparam int NZONE  = 24;
	localparam int NCHAN  = 24;
	localparam int NPHASE = 8;
	localparam int NSLOT  = 6;
	localparam int NRADAR = 2;
	localparam int NCAM   = 4;

	// timing: one tick every tenth of a second drives every user timer
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS       = 100_000_000;
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
	localparam int LEARN_MINUTES = 3;
	localparam int TICKS_PER_MIN = 600;
	localparam int LEARN_TICKS   = LEARN_MINUTES * TICKS_PER_MIN;
	localparam int FRAME_RATE_HZ = 30;
	localparam logic [7:0] TMR_MIN_TENTHS = 8'h01;
	localparam logic [7:0] TMR_MAX_TENTHS = 8'hFA;

	// bin periods in ticks: 10 s, 20 s, 1, 5, 15, 30, 60 min
	localparam logic [15:0] BIN_TICKS [8] = '{16'h0064, 16'h00C8, 16'h0258, 16'h0BB8,
		16'h2328, 16'h4650, 16'h8CA0, 16'h8CA0};

	// register word addresses
	localparam logic [7:0] A_CTRL      = 8'h00;
	localparam logic [7:0] A_STATUS    = 8'h01;
	localparam logic [7:0] A_FORCE     = 8'h02;
	localparam logic [7:0] A_ALARM     = 8'h03;
	localparam logic [7:0] A_BIN       = 8'h04;
	localparam logic [7:0] A_DWELL     = 8'h05;
	localparam logic [7:0] A_RADAR     = 8'h06;
	localparam logic [7:0] A_CALLS     = 8'h07;
	localparam logic [2:0] R_ZONE      = 3'h1;
	localparam logic [2:0] R_CHAN      = 3'h2;
	localparam logic [2:0] R_SLOT      = 3'h3;
	localparam logic [2:0] R_TOTAL     = 3'h4;
	localparam logic [2:0] R_BINCNT    = 3'h5;
	localparam logic [2:0] R_OCC       = 3'h6;
	localparam logic [2:0] R_SPEED     = 3'h7;

	// field positions
	localparam int CTRL_COMMIT  = 0;
	localparam int CTRL_AUTOVID = 1;
	localparam int ZC_SW_EN     = 7;
	localparam int ZC_ON_RED    = 16;
	localparam int CC_AND       = 24;
	localparam int RC_QUAL0     = 16;
	localparam int AL_EN        = 5;
	localparam int SL_EN        = 5;

	// reset values
	localparam logic [23:0] FORCE_RST = 24'hFFFFFF;
	localparam logic [15:0] DWELL_RST = 16'h0032;
	localparam logic [16:0] ZONE_RST  = 17'h00A00;

	typedef enum logic [1:0] {M_PRESENCE, M_PULSE, M_EXTEND, M_DELAY} dzol_mode_e;
endpackage

// *** dzol_sva.sv ***
// assertion checker watching the ports of the detection zone output logic
`timescale 1ns/100ps
`default_nettype none
module dzol_sva #(
	parameter int TICK_CYC  = 10,
	parameter int LEARN_TCK = 5
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        low_vis,
	input  wire logic [1:0]  radar_present,
	input  wire logic [3:0]  cam_valid,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_rdata,
	input  wire logic [23:0] call_out,
	input  wire logic        alarm_out,
	input  wire logic [1:0]  radar_call,
	input  wire logic [1:0]  video_sel,
	input  wire logic        learning
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// one spare tick allows for the unknown phase of the first tick
	localparam int LEARN_MAX = (LEARN_TCK + 1) * TICK_CYC + 4;
	int         learn_cnt_q;
	logic [3:0] cam_q;
	always_ff @(posedge sys_clk) begin
		if (reset || !learning)
			learn_cnt_q <= 0;
		else
			learn_cnt_q <= learn_cnt_q + 1;
	end
	always_ff @(posedge sys_clk) begin
		cam_q <= cam_valid;
	end
	a_reset_calls_all: assert property ($fell(reset) |-> call_out == 24'hFFFFFF && learning)
		else $error("calls or learning not set on leaving reset");
	a_learn_never_back: assert property (!learning |=> !learning)
		else $error("learning returned without reset");
	a_learn_bounded: assert property (learn_cnt_q <= LEARN_MAX)
		else $error("learning window too long");
	a_alarm_has_cause: assert property (alarm_out |-> $past(low_vis))
		else $error("alarm without low visibility");
	a_alarm_clears: assert property ($fell(low_vis) |=> !alarm_out)
		else $error("alarm stayed after low visibility cleared");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside read answer cycle");
	a_calls_readback: assert property (reg_rd && reg_addr == dzol_pkg::A_CALLS
		|=> reg_rdata[23:0] == $past(call_out))
		else $error("call readback differs from call outputs");
	a_radar_cause: assert property ((radar_call & ~$past(radar_present)) == 2'h0)
		else $error("radar call without presence");
	a_video_valid: assert property ($changed(video_sel) |-> cam_q[video_sel])
		else $error("video switched to invalid input");
	c_low_vis: cover property (alarm_out);
	c_radar_both: cover property (radar_call == 2'h3);
	c_learn_end: cover property ($fell(learning));
endmodule // dzol_sva
bind dzol_top dzol_sva #(.TICK_CYC(TICK_CYC), .LEARN_TCK(LEARN_TCK)) i_sva (.sys_clk, .reset,
	.low_vis, .radar_present, .cam_valid, .reg_addr, .reg_rd, .reg_rdata, .call_out, .alarm_out,
	.radar_call, .video_sel, .learning);
`default_nettype wire

// *** dzol_top.sv ***
// detection zone output logic: zone timing, call channels, counting, radar and video switching
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - low visibility forces every affected zone's channel into continuous call
// - low visibility drives the chosen alarm channel and a dedicated alarm output
// - forced calls end by themselves when low visibility clears
// - keeps configuration and state for twenty-four zones
// - two independent radar trigger points with their own outputs
// - twenty-four call channels, each mapping a set of zones
// - zones on a channel combine by OR, or by AND when selected
// - zone and channel edits go to shadow settings; their live settings change only on commit
// - zone results are taken once per frame strobe, all zones in parallel
// - all channels with a zone mapped call during background learning, at most three minutes
// - each zone runs in presence, pulse, extend or delay mode
// - pulse, extend and delay times run from 0.1 s to 25.0 s
// - up to six counting slots keep vehicle totals for readout
// - counting slots bin speed sum and occupancy over a chosen period
// - green, yellow and red status accepted for eight phases
// - a zone switches between two modes by its phase's state
// - radar outputs fire on presence, or only above a speed threshold
// - auto switching cycles the video output with a programmed dwell
// - interference or sensor loss puts a call on every active channel
module dzol_top #(
	parameter int TICK_CYC  = dzol_pkg::TICK_CYCLES,
	parameter int LEARN_TCK = dzol_pkg::LEARN_TICKS
) (
	input  wire logic                              sys_clk,
	input  wire logic                              reset,
	input  wire logic                              frame_strobe,
	input  wire logic [dzol_pkg::NZONE-1:0]        zone_detect,
	input  wire logic                              low_vis,
	input  wire logic                              interference,
	input  wire logic                              sensor_lost,
	input  wire logic [dzol_pkg::NPHASE-1:0]       phase_green_pin,
	input  wire logic [dzol_pkg::NPHASE-1:0]       phase_yellow_pin,
	input  wire logic [dzol_pkg::NPHASE-1:0]       phase_red_pin,
	input  wire logic [dzol_pkg::NRADAR-1:0]       radar_present,
	input  wire logic [dzol_pkg::NRADAR*8-1:0]     radar_speed,
	input  wire logic [dzol_pkg::NSLOT*8-1:0]      slot_speed,
	input  wire logic [dzol_pkg::NCAM-1:0]         cam_valid,
	input  wire logic [7:0]                        reg_addr,
	input  wire logic [31:0]                       reg_wdata,
	input  wire logic                              reg_wr,
	input  wire logic                              reg_rd,
	output var  logic [31:0]                       reg_rdata,
	output var  logic [dzol_pkg::NCHAN-1:0]        call_out,
	output var  logic                              alarm_out,
	output var  logic [dzol_pkg::NRADAR-1:0]       radar_call,
	output var  logic [$clog2(dzol_pkg::NCAM)-1:0] video_sel,
	output var  logic                              learning
);
	localparam int NZ = dzol_pkg::NZONE;
	localparam int NC = dzol_pkg::NCHAN;
	localparam int NS = dzol_pkg::NSLOT;
	localparam int CW = $clog2(dzol_pkg::NCAM);

	logic [31:0]        tick_cnt_q;
	logic               tick_q;
	logic [15:0]        learn_cnt_q;
	logic               learning_q;
	logic [NZ-1:0]      det_q;
	logic [NZ-1:0]      det_prev_q;
	logic [NZ-1:0]      onset;
	logic [NZ-1:0]      zone_call_q;
	logic [23:0]        ph_meta_q;
	logic [23:0]        ph_sync_q;
	logic [7:0]         green;
	logic [7:0]         red;
	logic [16:0]        zone_sh_q  [NZ];
	logic [16:0]        zone_act_q [NZ];
	logic [24:0]        chan_sh_q  [NC];
	logic [24:0]        chan_act_q [NC];
	logic [23:0]        force_q;
	logic [5:0]         alarm_q;
	logic [2:0]         bin_sel_q;
	logic [15:0]        dwell_q;
	logic [17:0]        radar_q;
	logic               auto_vid_q;
	logic [5:0]         slot_cfg_q [NS];
	logic [15:0]        total_q    [NS];
	logic [15:0]        bcnt_q     [NS];
	logic [15:0]        bocc_q     [NS];
	logic [23:0]        bspd_q     [NS];
	logic [15:0]        acnt_q     [NS];
	logic [15:0]        aocc_q     [NS];
	logic [23:0]        aspd_q     [NS];
	logic [15:0]        bin_tmr_q;
	logic               bin_end;
	logic [15:0]        dwell_cnt_q;
	logic [CW-1:0]      vsel_q;
	logic [NC-1:0]      call_q;
	logic               alarm_q_out;
	logic [1:0]         radar_call_q;
	logic [31:0]        rdata_q;
	logic               commit;
	logic               safe;

	assign commit  = reg_wr && reg_addr == dzol_pkg::A_CTRL && reg_wdata[dzol_pkg::CTRL_COMMIT];
	assign green   = ph_sync_q[7:0];
	assign red     = ph_sync_q[23:16];
	assign safe    = learning_q || interference || sensor_lost;
	assign bin_end = tick_q && bin_tmr_q == dzol_pkg::BIN_TICKS[bin_sel_q] - 16'h0001;

	// tenth-second tick enable
	always_ff @(posedge sys_clk) begin
		if (reset || tick_cnt_q == 32'(TICK_CYC - 1)) begin
			tick_cnt_q <= 32'h0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
		end
		tick_q <= !reset && tick_cnt_q == 32'(TICK_CYC - 1);
	end

	// background learning window after start-up
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			learn_cnt_q <= 16'h0;
			learning_q  <= 1'b1;
		end else if (learning_q && tick_q) begin
			learn_cnt_q <= learn_cnt_q + 16'h1;
			learning_q  <= learn_cnt_q != 16'(LEARN_TCK - 1);
		end
	end

	// phase status pins cross in through two flops
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ph_meta_q <= 24'h0;
			ph_sync_q <= 24'h0;
		end else begin
			ph_meta_q <= {phase_red_pin, phase_yellow_pin, phase_green_pin};
			ph_sync_q <= ph_meta_q;
		end
	end

	// zone results sampled once per frame
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			det_q      <= '0;
			det_prev_q <= '0;
		end else begin
			if (frame_strobe) begin
				det_q <= zone_detect;
			end
			det_prev_q <= det_q;
		end
	end
	assign onset = det_q & ~det_prev_q;

	// control registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			force_q    <= dzol_pkg::FORCE_RST;
			alarm_q    <= 6'h0;
			bin_sel_q  <= 3'h0;
			dwell_q    <= dzol_pkg::DWELL_RST;
			radar_q    <= 18'h0;
			auto_vid_q <= 1'b0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				dzol_pkg::A_CTRL:  auto_vid_q <= reg_wdata[dzol_pkg::CTRL_AUTOVID];
				dzol_pkg::A_FORCE: force_q    <= reg_wdata[23:0];
				dzol_pkg::A_ALARM: alarm_q    <= reg_wdata[5:0];
				dzol_pkg::A_BIN:   bin_sel_q  <= reg_wdata[2:0];
				dzol_pkg::A_DWELL: dwell_q    <= reg_wdata[15:0];
				dzol_pkg::A_RADAR: radar_q    <= reg_wdata[17:0];
				default: ;
			endcase
		end
	end

	// shadow and live zone/channel settings; live copies change only on commit
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int z = 0; z < NZ; z++) begin
				zone_sh_q[z]  <= dzol_pkg::ZONE_RST;
				zone_act_q[z] <= dzol_pkg::ZONE_RST;
			end
			for (int c = 0; c < NC; c++) begin
				chan_sh_q[c]  <= {1'b0, 24'h000001 << c};
				chan_act_q[c] <= {1'b0, 24'h000001 << c};
			end
		end else begin
			for (int z = 0; z < NZ; z++) begin
				if (reg_wr && reg_addr[7:5] == dzol_pkg::R_ZONE && reg_addr[4:0] == 5'(z)) begin
					zone_sh_q[z] <= reg_wdata[16:0];
				end
				if (commit) begin
					zone_act_q[z] <= zone_sh_q[z];
				end
			end
			for (int c = 0; c < NC; c++) begin
				if (reg_wr && reg_addr[7:5] == dzol_pkg::R_CHAN && reg_addr[4:0] == 5'(c)) begin
					chan_sh_q[c] <= reg_wdata[24:0];
				end
				if (commit) begin
					chan_act_q[c] <= chan_sh_q[c];
				end
			end
		end
	end

	// per-zone output timing
	for (genvar z = 0; z < NZ; z++) begin : g_zone
		logic [7:0]           tmr_q;
		logic [7:0]           tval;
		logic                 alt;
		dzol_pkg::dzol_mode_e mode;
		logic [2:0]           ph;

		assign ph   = zone_act_q[z][6:4];
		// second mode applies when not green, or only when red if so chosen
		assign alt  = zone_act_q[z][dzol_pkg::ZC_SW_EN] &&
			(zone_act_q[z][dzol_pkg::ZC_ON_RED] ? red[ph] : !green[ph]);
		assign mode = dzol_pkg::dzol_mode_e'(alt ? zone_act_q[z][3:2] : zone_act_q[z][1:0]);
		// out-of-range times are clamped rather than rejected
		assign tval = zone_act_q[z][15:8] < dzol_pkg::TMR_MIN_TENTHS ? dzol_pkg::TMR_MIN_TENTHS :
			zone_act_q[z][15:8] > dzol_pkg::TMR_MAX_TENTHS ? dzol_pkg::TMR_MAX_TENTHS :
			zone_act_q[z][15:8];

		always_ff @(posedge sys_clk) begin
			if (reset) begin
				tmr_q          <= 8'h0;
				zone_call_q[z] <= 1'b0;
			end else begin
				unique case (mode)
					dzol_pkg::M_PRESENCE: begin
						tmr_q          <= 8'h0;
						zone_call_q[z] <= det_q[z];
					end
					dzol_pkg::M_PULSE: begin
						if (onset[z]) begin
							tmr_q <= tval;
						end else if (tick_q && tmr_q != 8'h0) begin
							tmr_q <= tmr_q - 8'h1;
						end
						zone_call_q[z] <= onset[z] || tmr_q != 8'h0;
					end
					dzol_pkg::M_EXTEND: begin
						if (det_q[z]) begin
							tmr_q <= tval;
						end else if (tick_q && tmr_q != 8'h0) begin
							tmr_q <= tmr_q - 8'h1;
						end
						zone_call_q[z] <= det_q[z] || tmr_q != 8'h0;
					end
					dzol_pkg::M_DELAY: begin
						if (!det_q[z]) begin
							tmr_q <= 8'h0;
						end else if (tick_q && tmr_q < tval) begin
							tmr_q <= tmr_q + 8'h1;
						end
						zone_call_q[z] <= det_q[z] && tmr_q >= tval;
					end
				endcase
			end
		end
	end

	// call channels
	for (genvar c = 0; c < NC; c++) begin : g_chan
		logic [23:0] m;
		logic        hit;
		logic        forced;
		logic        alarm_hit;

		assign m         = chan_act_q[c][23:0];
		assign hit       = chan_act_q[c][dzol_pkg::CC_AND] ?
			(m != 24'h0 && &(zone_call_q | ~m)) : |(zone_call_q & m);
		assign forced    = low_vis && |(m & force_q);
		assign alarm_hit = low_vis && alarm_q[dzol_pkg::AL_EN] && alarm_q[4:0] == 5'(c);

		always_ff @(posedge sys_clk) begin
			if (reset) begin
				call_q[c] <= 1'b1;
			end else begin
				call_q[c] <= hit || forced || alarm_hit || (safe && m != 24'h0);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			alarm_q_out <= 1'b0;
		end else begin
			alarm_q_out <= low_vis && alarm_q[dzol_pkg::AL_EN];
		end
	end

	// radar trigger points
	for (genvar r = 0; r < dzol_pkg::NRADAR; r++) begin : g_radar
		always_ff @(posedge sys_clk) begin
			if (reset) begin
				radar_call_q[r] <= 1'b0;
			end else begin
				radar_call_q[r] <= radar_present[r] && (!radar_q[dzol_pkg::RC_QUAL0 + r] ||
					radar_speed[r*8 +: 8] > radar_q[r*8 +: 8]);
			end
		end
	end

	// bin period timer
	always_ff @(posedge sys_clk) begin
		if (reset || bin_end) begin
			bin_tmr_q <= 16'h0;
		end else if (tick_q) begin
			bin_tmr_q <= bin_tmr_q + 16'h1;
		end
	end

	// counting slots; an event in the closing cycle opens the new bin
	for (genvar s = 0; s < NS; s++) begin : g_slot
		logic [4:0] zs;
		logic       en;
		logic       cnt_ev;
		logic       occ_ev;

		assign zs     = slot_cfg_q[s][4:0];
		assign en     = slot_cfg_q[s][dzol_pkg::SL_EN] && zs < 5'(NZ);
		assign cnt_ev = en && onset[zs];
		assign occ_ev = en && frame_strobe && det_q[zs];

		always_ff @(posedge sys_clk) begin
			if (reset) begin
				slot_cfg_q[s] <= 6'h0;
			end else if (reg_wr && reg_addr[7:5] == dzol_pkg::R_SLOT && reg_addr[4:0] == 5'(s)) begin
				slot_cfg_q[s] <= reg_wdata[5:0];
			end
		end

		always_ff @(posedge sys_clk) begin
			if (reset) begin
				total_q[s] <= 16'h0;
			end else if (cnt_ev) begin
				total_q[s] <= total_q[s] + 16'h1;
			end
		end

		always_ff @(posedge sys_clk) begin
			if (reset) begin
				acnt_q[s] <= 16'h0;
				aocc_q[s] <= 16'h0;
				aspd_q[s] <= 24'h0;
				bcnt_q[s] <= 16'h0;
				bocc_q[s] <= 16'h0;
				bspd_q[s] <= 24'h0;
			end else if (bin_end) begin
				bcnt_q[s] <= acnt_q[s];
				bocc_q[s] <= aocc_q[s];
				bspd_q[s] <= aspd_q[s];
				acnt_q[s] <= {15'h0, cnt_ev};
				aocc_q[s] <= {15'h0, occ_ev};
				aspd_q[s] <= cnt_ev ? {16'h0, slot_speed[s*8 +: 8]} : 24'h0;
			end else begin
				acnt_q[s] <= acnt_q[s] + {15'h0, cnt_ev};
				aocc_q[s] <= aocc_q[s] + {15'h0, occ_ev};
				if (cnt_ev) begin
					aspd_q[s] <= aspd_q[s] + {16'h0, slot_speed[s*8 +: 8]};
				end
			end
		end
	end

	// monitored video output switching; invalid inputs are skipped
	function automatic logic [CW-1:0] next_cam(input logic [CW-1:0] cur,
		input logic [dzol_pkg::NCAM-1:0] ok);
		logic [CW-1:0] n;
		logic          found;
		n     = cur;
		found = 1'b0;
		for (int k = 1; k <= dzol_pkg::NCAM; k++) begin
			if (!found && ok[CW'((int'(cur) + k) % dzol_pkg::NCAM)]) begin
				n     = CW'((int'(cur) + k) % dzol_pkg::NCAM);
				found = 1'b1;
			end
		end
		return n;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			dwell_cnt_q <= 16'h0;
			vsel_q      <= '0;
		end else if (!auto_vid_q) begin
			dwell_cnt_q <= 16'h0;
		end else if (tick_q) begin
			if (dwell_cnt_q + 16'h1 >= dwell_q) begin
				dwell_cnt_q <= 16'h0;
				vsel_q      <= next_cam(vsel_q, cam_valid);
			end else begin
				dwell_cnt_q <= dwell_cnt_q + 16'h1;
			end
		end
	end

	// register read path; data only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (reset || !reg_rd) begin
			rdata_q <= 32'h0;
		end else if (reg_addr[7:5] == 3'h0) begin
			unique case (reg_addr)
				dzol_pkg::A_CTRL:   rdata_q <= {30'h0, auto_vid_q, 1'b0};
				dzol_pkg::A_STATUS: rdata_q <= {ph_sync_q, 2'h0, 2'(vsel_q), sensor_lost,
					interference, low_vis, learning_q};
				dzol_pkg::A_FORCE:  rdata_q <= {8'h0, force_q};
				dzol_pkg::A_ALARM:  rdata_q <= {26'h0, alarm_q};
				dzol_pkg::A_BIN:    rdata_q <= {29'h0, bin_sel_q};
				dzol_pkg::A_DWELL:  rdata_q <= {16'h0, dwell_q};
				dzol_pkg::A_RADAR:  rdata_q <= {14'h0, radar_q};
				dzol_pkg::A_CALLS:  rdata_q <= {8'h0, call_q};
				default:            rdata_q <= 32'h0;
			endcase
		end else if (reg_addr[7:5] == dzol_pkg::R_ZONE && reg_addr[4:0] < 5'(NZ)) begin
			rdata_q <= {15'h0, zone_sh_q[reg_addr[4:0]]};
		end else if (reg_addr[7:5] == dzol_pkg::R_CHAN && reg_addr[4:0] < 5'(NC)) begin
			rdata_q <= {7'h0, chan_sh_q[reg_addr[4:0]]};
		end else if (reg_addr[4:0] < 5'(NS)) begin
			unique case (reg_addr[7:5])
				dzol_pkg::R_SLOT:   rdata_q <= {26'h0, slot_cfg_q[reg_addr[2:0]]};
				dzol_pkg::R_TOTAL:  rdata_q <= {16'h0, total_q[reg_addr[2:0]]};
				dzol_pkg::R_BINCNT: rdata_q <= {16'h0, bcnt_q[reg_addr[2:0]]};
				dzol_pkg::R_OCC:    rdata_q <= {16'h0, bocc_q[reg_addr[2:0]]};
				dzol_pkg::R_SPEED:  rdata_q <= {8'h0, bspd_q[reg_addr[2:0]]};
				default:            rdata_q <= 32'h0;
			endcase
		end else begin
			rdata_q <= 32'h0;
		end
	end

	assign reg_rdata  = rdata_q;
	assign call_out   = call_q;
	assign alarm_out  = alarm_q_out;
	assign radar_call = radar_call_q;
	assign video_sel  = vsel_q;
	assign learning   = learning_q;
endmodule // dzol_top

`default_nettype wire

// *** testbench.sv ***
// self-checking testbench for the detection zone output logic
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        sys_clk, reset, frame_strobe, low_vis, interference, sensor_lost;
	logic        reg_wr, reg_rd, step, alarm_out, learning;
	logic [23:0] zone_detect, call_out;
	logic [7:0]  pg, py, pr, reg_addr;
	logic [1:0]  radar_present, radar_call, video_sel;
	logic [15:0] radar_speed;
	logic [47:0] slot_speed;
	logic [31:0] reg_wdata, reg_rdata, v;
	int          error_cnt = 0;
	int          check_count = 0;

	dzol_top #(.TICK_CYC(10), .LEARN_TCK(5)) i_dut (.sys_clk, .reset, .frame_strobe,
		.zone_detect, .low_vis, .interference, .sensor_lost, .phase_green_pin(pg),
		.phase_yellow_pin(py), .phase_red_pin(pr), .radar_present, .radar_speed,
		.slot_speed, .cam_valid(4'hB), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .call_out, .alarm_out, .radar_call, .video_sel, .learning);
	dzol_ctrl_model i_ctrl (.sys_clk, .reset, .step, .green(pg), .yellow(py), .red(pr));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// one frame strobe carrying the given detections; the level stays afterwards
	task automatic fr(input logic [23:0] det);
		@(posedge sys_clk);
		zone_detect <= det;
		frame_strobe <= 1'b1;
		@(posedge sys_clk);
		frame_strobe <= 1'b0;
	endtask
	task automatic calls(input logic [23:0] exp);
		cyc(3);
		chk({8'h00, call_out}, {8'h00, exp});
	endtask

	task automatic t_learn;
		chk({31'h0, learning}, 32'h1);
		chk({8'h00, call_out}, 32'h00FF_FFFF);
		for (int i = 0; i < 200 && learning !== 1'b0; i++)
			cyc(1);
		chk({31'h0, learning}, 32'h0);
		calls(24'h000000);
		$display("test learn done");
	endtask
	task automatic t_regs;
		logic [7:0]  a [7] = '{8'h02, 8'h03, 8'h10, 8'h66, 8'h40, 8'h57, 8'h38};
		logic [31:0] e [7] = '{32'hFFFFFF, 0, 0, 0, 32'h1, 32'h800000, 0};
		for (int i = 0; i < 7; i++) begin
			rd(a[i], v);
			chk(v, e[i]);
		end
		rd(8'h20, v);
		chk(v, 32'h0000_0A00);
		rd(dzol_pkg::A_DWELL, v);
		chk(v, 32'h0000_0032);
		wr(dzol_pkg::A_ALARM, 32'h25);
		rd(dzol_pkg::A_ALARM, v);
		chk(v, 32'h0000_0025);
		$display("test registers done");
	endtask
	task automatic t_lowvis;
		wr(dzol_pkg::A_FORCE, 32'h3);
		low_vis <= 1'b1;
		calls(24'h000023);
		chk({31'h0, alarm_out}, 32'h1);
		@(posedge sys_clk);
		low_vis <= 1'b0;
		calls(24'h000000);
		chk({31'h0, alarm_out}, 32'h0);
		$display("test low visibility done");
	endtask
	task automatic t_and;
		wr(8'h40, 32'h0100_0003);
		fr(24'h000001);
		calls(24'h000001);
		wr(dzol_pkg::A_CTRL, 32'h1);
		fr(24'h000001);
		calls(24'h000000);
		fr(24'h000003);
		calls(24'h000003);
		fr(24'h000000);
		calls(24'h000000);
		$display("test combine done");
	endtask
	task automatic t_modes;
		wr(8'h22, 32'h0202);
		wr(8'h23, 32'h0201);
		wr(8'h24, 32'h0203);
		wr(dzol_pkg::A_CTRL, 32'h1);
		fr(24'h00001C);
		calls(24'h00000C);
		cyc(40);
		chk({8'h00, call_out}, 32'h14);
		fr(24'h000000);
		calls(24'h000004);
		cyc(40);
		chk({8'h00, call_out}, 32'h0);
		$display("test modes done");
	endtask
	task automatic t_safe;
		@(posedge sys_clk);
		interference <= 1'b1;
		calls(24'hFFFFFF);
		rd(dzol_pkg::A_CALLS, v);
		chk(v, 32'h00FF_FFFF);
		@(posedge sys_clk);
		interference <= 1'b0;
		sensor_lost <= 1'b1;
		calls(24'hFFFFFF);
		@(posedge sys_clk);
		sensor_lost <= 1'b0;
		calls(24'h000000);
		$display("test safe state done");
	endtask
	task automatic t_radar;
		wr(dzol_pkg::A_RADAR, 32'h0001_0040);
		radar_speed <= 16'h1030;
		radar_present <= 2'h3;
		cyc(3);
		chk({30'h0, radar_call}, 32'h2);
		@(posedge sys_clk);
		radar_speed <= 16'h1050;
		cyc(3);
		chk({30'h0, radar_call}, 32'h3);
		@(posedge sys_clk);
		radar_present <= 2'h0;
		cyc(3);
		chk({30'h0, radar_call}, 32'h0);
		$display("test radar done");
	endtask
	task automatic t_phase_video;
		for (int k = 1; k <= 3; k++) begin
			@(posedge sys_clk);
			step <= 1'b1;
			@(posedge sys_clk);
			step <= 1'b0;
			cyc(5);
			rd(dzol_pkg::A_STATUS, v);
			chk({8'h0, v[31:8]}, {8'h0, 7'h7F, k == 2, 7'h0, k == 1, 7'h0, k == 3});
		end
		// zone 5: presence while its phase is green, a long delay otherwise
		wr(8'h25, 32'hFA8C);
		wr(dzol_pkg::A_CTRL, 32'h1);
		fr(24'h000020);
		calls(24'h000020);
		@(posedge sys_clk);
		step <= 1'b1;
		@(posedge sys_clk);
		step <= 1'b0;
		cyc(2);
		calls(24'h000000);
		wr(dzol_pkg::A_DWELL, 32'h2);
		wr(dzol_pkg::A_CTRL, 32'h2);
		rd(dzol_pkg::A_CTRL, v);
		chk(v & 32'h2, 32'h2);
		for (int i = 0; i < 100 && video_sel === 2'h0; i++)
			cyc(1);
		chk({30'h0, video_sel}, 32'h1);
		for (int i = 0; i < 100 && video_sel === 2'h1; i++)
			cyc(1);
		// input 2 is invalid and must be passed over
		chk({30'h0, video_sel}, 32'h3);
		$display("test phases and video done");
	endtask

	task automatic t_count;
		wr(8'h60, 32'h20);
		slot_speed <= 48'h2A;
		fr(24'h000001);
		fr(24'h000001);
		fr(24'h000000);
		cyc(2);
		rd(8'h80, v);
		chk(v, 32'h1);
		// wait for the bin holding these frames to close
		v = 32'h0;
		for (int i = 0; i < 600 && v === 32'h0; i++)
			rd(8'hA0, v);
		chk(v, 32'h1);
		rd(8'hC0, v);
		chk(v, 32'h2);
		rd(8'hE0, v);
		chk(v, 32'h2A);
		$display("test counting done");
	endtask

	initial begin
		#50us;
		error_cnt++;
		end_of_test;
	end
	initial begin
		reset = 1'b1;
		{frame_strobe, low_vis, interference, sensor_lost, reg_wr, reg_rd, step} = 7'h0;
		zone_detect = 24'h0;
		radar_present = 2'h0;
		radar_speed = 16'h0;
		slot_speed = 48'h0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		cyc(1);
		t_learn;
		t_regs;
		t_lowvis;
		t_and;
		t_modes;
		t_safe;
		t_radar;
		t_phase_video;
		t_count;
		end_of_test;
	end
endmodule // testbench
`default_nettype wire
